// ---- hw/spi_chain_pkg.sv ----
// package: constants and carrier types for the serial daisy-chain slave
// Overview of operation
// - fixed 32-bit full-duplex frames shifted on the host serial clock
// - mode 1: clock idles low, launch on rising edge, sample on falling
// - chip select active low; clock and data ignored while it is high
// - valid write frames update internal configuration registers
// - read frames return the status word or a stored configuration register on serial output
// - device is a 32-bit shift stage; frame passes after 32 clocks
// - reset and disable pulses shorter than the filter time are ignored
// - frames msb first; lsb is odd parity, checked on every frame
// - reply to a frame is shifted out during the following frame
// - all-zero reply after reset, bad command, bad count or parity
// - during reset serial output is high impedance, inputs ignored
package spi_chain_pkg;
   localparam int unsigned FRAME_BITS    = 32;
   localparam int unsigned CFG_REGS      = 16;
   localparam logic [31:0] REPLY_ZERO    = 32'h0000_0000;
   localparam int unsigned CMD_MSB       = 31;
   localparam int unsigned CMD_LSB       = 28;
   localparam int unsigned RW_BIT        = 27;
   localparam int unsigned DATA_MSB      = 26;
   localparam int unsigned DATA_LSB      = 1;
   localparam logic [3:0]  CMD_STATUS    = 4'hf;
   localparam logic [3:0]  CMD_LAST_CFG  = 4'hd;
   localparam int unsigned CLK_PERIOD_NS = 25;
   // filter time lies 0.5..5.0 us; 0.5 us taken as the minimum stable width
   localparam int unsigned FILT_TIME_NS  = 500;
   localparam int unsigned FILT_CYCLES   = (FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned FIFO_DEPTH    = 4;

   typedef struct packed {
      logic [3:0]  cmd;
      logic        wr;
      logic [25:0] data;
      logic        parity;
   } frame_type;

   typedef struct packed {
      logic [31:0] bits;
      logic [5:0]  count;
   } rx_word_type;

   typedef enum logic [1:0] {
      IDLE_S  = 2'b00,
      CHECK_S = 2'b01,
      APPLY_S = 2'b10
   } proc_state_type;

   function automatic logic odd_parity_ok(input logic [31:0] w);
      return ^w;
   endfunction
endpackage

// ---- hw/word_fifo.sv ----
// small valid/ready FIFO between link and core domains
`timescale 1ns/1ps
module word_fifo #(
   parameter int unsigned WIDTH = 38,
   parameter int unsigned DEPTH = 4
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   output logic [WIDTH-1:0]      out_data_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wp_r;
   logic [AW-1:0]    rp_r;
   logic [AW:0]      cnt_r;
   logic             push;
   logic             pop;

   assign in_ready_o  = (cnt_r != DEPTH[AW:0]);
   assign out_valid_o = (cnt_r != '0);
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;
   assign out_data_o  = mem_r[rp_r];

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_r[wp_r] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   a_fifo_no_over : assert property (@(posedge clk_i) disable iff (rst_i)
      cnt_r == DEPTH[AW:0] |-> !in_ready_o)
      else $error("fifo accepts while full");
endmodule

// ---- hw/predriver_spi_slave.sv ----
// serial slave with daisy-chain shift stage, frame checks and input filters
`timescale 1ns/1ps
module predriver_spi_slave
   import spi_chain_pkg::*;
(
   input  wire logic        CORE_CLK_I,
   input  wire logic        RESET_I,
   input  wire logic        SCK_I,
   input  wire logic        CS_N_I,
   input  wire logic        SDI_I,
   output logic             SDO_O,
   output logic             SDO_OE_O,
   input  wire logic        RESET_N_INPUT_I,
   input  wire logic        DISABLE_HIGH_INPUT_I,
   input  wire logic        DISABLE_LOW_BIDIR_I,
   input  wire logic [31:0] STATUS_I,
   output logic [31:0]      CFG_DATA_O,
   output logic [3:0]       CFG_ADDR_O,
   output logic             CFG_WE_O,
   output logic             RESET_N_FILT_O,
   output logic             DISABLE_HIGH_FILT_O,
   output logic             DISABLE_LOW_FILT_O,
   output logic             FRAME_ERR_O
);
   // ---------------- core domain: synchronisers and filters
   logic [2:0] pin_s1_r;
   logic [2:0] pin_s2_r;
   logic [2:0] filt_r;
   logic [4:0] filt_cnt_r [3];
   logic       dev_rst;

   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         pin_s1_r <= 3'h5;
         pin_s2_r <= 3'h5;
      end else begin
         pin_s1_r <= {DISABLE_LOW_BIDIR_I, DISABLE_HIGH_INPUT_I, RESET_N_INPUT_I};
         pin_s2_r <= pin_s1_r;
      end
   end

   // a level change is accepted only after it stays put for the filter count
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         filt_r <= 3'h5;
         for (int i = 0; i < 3; i++) begin
            filt_cnt_r[i] <= '0;
         end
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (pin_s2_r[i] == filt_r[i]) begin
               filt_cnt_r[i] <= '0;
            end else if (filt_cnt_r[i] == 5'(FILT_CYCLES - 1)) begin
               filt_r[i]     <= pin_s2_r[i];
               filt_cnt_r[i] <= '0;
            end else begin
               filt_cnt_r[i] <= filt_cnt_r[i] + 5'h01;
            end
         end
      end
   end

   assign RESET_N_FILT_O      = filt_r[0];
   assign DISABLE_HIGH_FILT_O = filt_r[1];
   assign DISABLE_LOW_FILT_O  = filt_r[2];
   assign dev_rst             = RESET_I || !filt_r[0];

   // reset level for the link side; the link clock stops between frames, so
   // a sync chain on it would eat the first edges of a frame. this level
   // settles long before the first clock edge after chip select falls
   logic link_rst_r;
   always_ff @(posedge CORE_CLK_I) begin
      link_rst_r <= dev_rst;
   end

   // ---------------- link domain
   logic [31:0] shift_r;
   logic [5:0]  bit_cnt_r;
   logic [31:0] reply_r;
   logic [31:0] sdo_hold_r;

   // sample on falling edge; frame state restarts while chip select is high
   always_ff @(negedge SCK_I or posedge CS_N_I) begin
      if (CS_N_I) begin
         bit_cnt_r <= '0;
      end else if (!link_rst_r) begin
         // top bit sticks after a whole frame, so long chains never look empty
         bit_cnt_r <= {bit_cnt_r[5] | (bit_cnt_r[4:0] == 5'h1f),
                       bit_cnt_r[4:0] + 5'h01};
      end
   end

   logic [31:0] load_word;
   assign load_word = link_rst_r ? REPLY_ZERO : reply_r;

   // launch on rising edge; at bit 0 load the pending reply, at each later multiple of 32 the received word
   always_ff @(negedge SCK_I) begin
      if (!CS_N_I && !link_rst_r) begin
         shift_r <= {shift_r[30:0], SDI_I};
      end
   end

   always_ff @(posedge SCK_I) begin
      if (!CS_N_I) begin
         if (bit_cnt_r[4:0] == 5'h00 && !bit_cnt_r[5]) begin
            sdo_hold_r <= {load_word[30:0], 1'b0};
            SDO_O      <= load_word[31];
         end else if (bit_cnt_r[4:0] == 5'h00) begin
            // daisy chain: after 32 clocks the received frame leaves here
            sdo_hold_r <= {shift_r[30:0], 1'b0};
            SDO_O      <= shift_r[31];
         end else begin
            sdo_hold_r <= {sdo_hold_r[30:0], 1'b0};
            SDO_O      <= sdo_hold_r[31];
         end
      end
   end

   // frame passes out at chip select release with its clock count
   rx_word_type cs_word;
   logic        cs_valid;
   logic        cs_rise_tgl_r;
   always_ff @(posedge CS_N_I or posedge dev_rst) begin
      if (dev_rst) begin
         cs_rise_tgl_r <= 1'b0;
      end else begin
         cs_rise_tgl_r <= ~cs_rise_tgl_r;
      end
   end
   always_ff @(posedge CS_N_I) begin
      cs_word.bits  <= shift_r;
      cs_word.count <= bit_cnt_r;
   end

   assign SDO_OE_O = !CS_N_I && !dev_rst;

   // ---------------- core domain: event crossing into FIFO
   logic        tg_s1_r;
   logic        tg_s2_r;
   logic        tg_s3_r;
   logic        fifo_in_ready;
   rx_word_type fifo_out;
   logic        fifo_out_valid;
   logic        fifo_out_ready;

   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         tg_s1_r <= 1'b0;
         tg_s2_r <= 1'b0;
         tg_s3_r <= 1'b0;
      end else begin
         tg_s1_r <= cs_rise_tgl_r;
         tg_s2_r <= tg_s1_r;
         tg_s3_r <= tg_s2_r;
      end
   end
   assign cs_valid = (tg_s2_r != tg_s3_r) && !dev_rst;

   word_fifo #(
      .WIDTH ($bits(rx_word_type)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (CORE_CLK_I),
      .rst_i       (dev_rst),
      .in_data_i   (cs_word),
      .in_valid_i  (cs_valid),
      .in_ready_o  (fifo_in_ready),
      .out_data_o  (fifo_out),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (fifo_out_ready)
   );

   // ---------------- core domain: frame processing
   proc_state_type state_r;
   proc_state_type state_nxt;
   frame_type      frm_r;
   logic           ok_r;
   logic           empty_r;
   logic [31:0]    cfg_mem_r [CFG_REGS];
   logic [31:0]    reply_core_r;

   assign fifo_out_ready = (state_r == IDLE_S);

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         IDLE_S:  if (fifo_out_valid) state_nxt = CHECK_S;
         CHECK_S: state_nxt = APPLY_S;
         APPLY_S: state_nxt = IDLE_S;
         default: state_nxt = IDLE_S;
      endcase
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (dev_rst) begin
         state_r <= IDLE_S;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (dev_rst) begin
         frm_r   <= '0;
         ok_r    <= 1'b0;
         empty_r <= 1'b0;
      end else if (state_r == IDLE_S && fifo_out_valid) begin
         frm_r   <= fifo_out.bits;
         // empty select without clocks is just ignored later
         empty_r <= (fifo_out.count == 6'h00);
         ok_r    <= (fifo_out.count[4:0] == 5'h00) && (fifo_out.count != 6'h00)
                  && odd_parity_ok(fifo_out.bits);
      end
   end

   logic valid_cmd;
   assign valid_cmd = (frm_r.cmd <= CMD_LAST_CFG) || (frm_r.cmd == CMD_STATUS && !frm_r.wr);

   always_ff @(posedge CORE_CLK_I) begin
      if (dev_rst) begin
         reply_core_r <= REPLY_ZERO;
         CFG_WE_O     <= 1'b0;
         CFG_ADDR_O   <= '0;
         CFG_DATA_O   <= '0;
         FRAME_ERR_O  <= 1'b0;
         for (int i = 0; i < CFG_REGS; i++) begin
            cfg_mem_r[i] <= '0;
         end
      end else begin
         CFG_WE_O <= 1'b0;
         if (state_r == APPLY_S && !empty_r) begin
            FRAME_ERR_O <= !(ok_r && valid_cmd);
            if (!ok_r || !valid_cmd) begin
               reply_core_r <= REPLY_ZERO;
            end else if (frm_r.wr) begin
               cfg_mem_r[frm_r.cmd] <= {5'h00, frm_r.data, 1'b0};
               CFG_WE_O             <= 1'b1;
               CFG_ADDR_O           <= frm_r.cmd;
               CFG_DATA_O           <= {6'h00, frm_r.data};
               reply_core_r         <= {frm_r.cmd, 1'b1, frm_r.data, ~(^{frm_r.cmd, 1'b1, frm_r.data})};
            end else if (frm_r.cmd == CMD_STATUS) begin
               reply_core_r <= {frm_r.cmd, 1'b0, STATUS_I[25:0],
                                ~(^{frm_r.cmd, STATUS_I[25:0]})};
            end else begin
               reply_core_r <= {frm_r.cmd, 1'b0, cfg_mem_r[frm_r.cmd][26:1],
                                ~(^{frm_r.cmd, cfg_mem_r[frm_r.cmd][26:1]})};
            end
         end
      end
   end

   // reply word is stable long before the next frame's first rising edge;
   // relies on the minimum chip select high time, so no handshake is spent
   always_ff @(posedge CORE_CLK_I) begin
      reply_r <= reply_core_r;
   end

   a_zero_on_bad : assert property (@(posedge CORE_CLK_I) disable iff (dev_rst)
      state_r == APPLY_S && !ok_r && !empty_r |=> reply_core_r == REPLY_ZERO)
      else $error("bad frame did not clear reply");
   a_write_pulse : assert property (@(posedge CORE_CLK_I) disable iff (dev_rst)
      CFG_WE_O |-> $past(state_r) == APPLY_S && $past(ok_r))
      else $error("write without checked frame");
   a_write_fields : assert property (@(posedge CORE_CLK_I) disable iff (dev_rst)
      CFG_WE_O |-> CFG_ADDR_O <= CMD_LAST_CFG)
      else $error("write to a non-config address");
   a_empty_ignored : assert property (@(posedge CORE_CLK_I) disable iff (dev_rst)
      state_r == APPLY_S && empty_r |=> $stable(reply_core_r) && !CFG_WE_O)
      else $error("empty frame changed reply");
   a_sdo_off_rst : assert property (@(posedge CORE_CLK_I) RESET_I |-> !SDO_OE_O)
      else $error("sdo driven in reset");
   a_filter_short : assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
      $changed(filt_r[0]) |-> $past(filt_cnt_r[0]) == 5'(FILT_CYCLES - 1))
      else $error("filter passed short pulse");
endmodule

// ---- sim/spi_host_model.sv ----
// host model: drives the serial link in mode 1, clock only inside frames
`timescale 1ns/1ps
module spi_host_model (
   output logic      sck_o,
   output logic      cs_n_o,
   output logic      sdi_o,
   input  wire logic sdo_i
);
   localparam time HALF = 80ns;
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      sdi_o = 1'b1;
   end
   // n bits, msb first; the far frame goes first when chained
   task automatic xfer(input logic [63:0] tx, input int n, output logic [63:0] rx);
      rx = '0;
      cs_n_o = 1'b0;
      #600ns;
      for (int i = n - 1; i >= 0; i--) begin
         sck_o = 1'b1;
         sdi_o = tx[i];
         #HALF;
         sck_o = 1'b0;
         rx = {rx[62:0], sdo_i};
         #HALF;
      end
      #100ns;
      cs_n_o = 1'b1;
      // line has a pull-up, so released data idles high
      sdi_o = 1'b1;
      #2us;
   endtask
endmodule

// ---- sim/predriver_spi_slave_daisy_chain_test.sv ----
// self-checking bench for the serial daisy-chain slave
`timescale 1ns/1ps
module predriver_spi_slave_daisy_chain_test;
   import spi_chain_pkg::*;
   logic        core_clk;
   logic        reset;
   logic        sck;
   logic        cs_n;
   logic        sdi;
   logic        sdo;
   logic        sdo_oe;
   logic        sdo_w;
   logic        frame_err;
   logic        cfg_we;
   logic [2:0]  pins;
   logic [2:0]  filt;
   logic [3:0]  cfg_addr;
   logic [31:0] cfg_data;
   logic [31:0] status;
   logic [63:0] rx;
   int          fails = 0;
   int          tests_run = 0;
   int          we_count = 0;

   // undriven output shows the inverse so a stale value never matches
   assign sdo_w = sdo_oe ? sdo : ~sdo;

   predriver_spi_slave u_dut (
      .CORE_CLK_I           (core_clk),
      .RESET_I              (reset),
      .SCK_I                (sck),
      .CS_N_I               (cs_n),
      .SDI_I                (sdi),
      .SDO_O                (sdo),
      .SDO_OE_O             (sdo_oe),
      .RESET_N_INPUT_I      (pins[0]),
      .DISABLE_HIGH_INPUT_I (pins[1]),
      .DISABLE_LOW_BIDIR_I  (pins[2]),
      .STATUS_I             (status),
      .CFG_DATA_O           (cfg_data),
      .CFG_ADDR_O           (cfg_addr),
      .CFG_WE_O             (cfg_we),
      .RESET_N_FILT_O       (filt[0]),
      .DISABLE_HIGH_FILT_O  (filt[1]),
      .DISABLE_LOW_FILT_O   (filt[2]),
      .FRAME_ERR_O          (frame_err)
   );
   spi_host_model u_host (.sck_o(sck), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo_w));

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) if (cfg_we === 1'b1) we_count <= we_count + 1;

   task automatic check(string what, logic [63:0] exp, logic [63:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic finish_test();
      if (fails == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   function automatic logic [31:0] mk(logic [3:0] c, logic w, logic [25:0] d);
      logic [31:0] f;
      f = {c, w, d, 1'b0};
      f[0] = ~^f[31:1];
      return f;
   endfunction

   task automatic t_chain();
      logic [31:0] a;
      logic [31:0] b;
      int          n;
      a = mk(4'h3, 1'b1, 26'h2aa_5555);
      b = mk(4'h5, 1'b1, 26'h155_aaaa);
      n = we_count;
      u_host.xfer({a, b}, 64, rx);
      check("reply after reset", 0, rx[63:32]);
      check("chain pass", a, rx[31:0]);
      check("write count", n + 1, we_count);
      check("cfg addr", 4'h5, cfg_addr);
      check("cfg data", b[26:1], cfg_data[25:0]);
   endtask

   task automatic t_errors();
      logic [63:0] bad [3];
      int          nb [3];
      int          n;
      bad[0] = {32'h0, mk(4'h2, 1'b1, 26'h1) ^ 32'h1};
      bad[1] = {32'h0, mk(4'he, 1'b1, 26'h1)};
      bad[2] = {31'h0, mk(4'h2, 1'b1, 26'h1), 1'b1};
      nb = '{32, 32, 33};
      for (int i = 0; i < 3; i++) begin
         n = we_count;
         u_host.xfer(bad[i], nb[i], rx);
         check("refused write", n, we_count);
         check("frame error", 1, frame_err);
         u_host.xfer({32'h0, mk(CMD_STATUS, 1'b0, 26'h0)}, 32, rx);
         check("zero reply", 0, rx[31:0]);
      end
   endtask

   task automatic t_status();
      u_host.xfer({32'h0, mk(CMD_STATUS, 1'b0, 26'h0)}, 32, rx);
      check("status data", status[25:0], rx[26:1]);
      check("reply parity", 1, ^rx[31:0]);
      check("released out", 0, sdo_oe);
      u_host.xfer('0, 0, rx);
      check("empty frame error", 0, frame_err);
      u_host.xfer({32'h0, mk(CMD_STATUS, 1'b0, 26'h0)}, 32, rx);
      check("status after empty", status[25:0], rx[26:1]);
   endtask

   task automatic pulse(int pin, int len, logic exp_low);
      logic seen;
      seen = 1'b0;
      for (int i = 0; i < len + 4; i++) begin
         @(posedge core_clk);
         pins[pin] <= (i < len) ? 1'b0 : 1'b1;
         seen |= (filt[pin] === 1'b0);
      end
      check("filtered pin", exp_low, seen);
      repeat (60) @(posedge core_clk);
   endtask

   initial begin
      reset = 1'b1;
      pins = 3'b111;
      status = 32'h0123_4567;
      repeat (3) @(posedge core_clk);
      check("oe in reset", 0, sdo_oe);
      reset <= 1'b0;
      repeat (30) @(posedge core_clk);
      t_chain();
      t_errors();
      t_status();
      for (int p = 0; p < 3; p++) begin
         pulse(p, 10, 1'b0);
         pulse(p, 40, 1'b1);
      end
      u_host.xfer({32'h0, mk(CMD_STATUS, 1'b0, 26'h0)}, 32, rx);
      check("reply after pin reset", 0, rx[31:0]);
      finish_test();
   end

   initial begin
      #2ms;
      fails++;
      finish_test();
   end
endmodule
